// [common/cfg_defs.svh]
`ifndef CFG_DEFS_SVH
`define CFG_DEFS_SVH

// outputs gated by default (four-output variant)
`define CFG_NUM_OUT          4
// input clock ceiling in MHz
`define CFG_FIN_MAX_MHZ      250
// input cycles held off after power-up
`define CFG_POWERUP_CYCLES   4
// enable latency in half cycles after the falling-edge sample (3.5 cycles)
`define CFG_EN_HALF_CYCLES   7
// disable latency in half cycles after the falling-edge sample (4.5 cycles)
`define CFG_DIS_HALF_CYCLES  9
// nominal weak pull-down in kilo-ohm
`define CFG_PULLDOWN_KOHM    100

`endif

// [common/cfg_pkg.sv]
package cfg_pkg;
    // per-output gate state
    typedef enum logic [1:0] {
        CFG_OFF  = 2'b00,
        CFG_WAKE = 2'b01,
        CFG_ON   = 2'b10,
        CFG_STOP = 2'b11
    } cfg_gate_t;
endpackage : cfg_pkg

// [logic/cfg_fanout_gate.sv]

`include "cfg_defs.svh"

module cfg_fanout_gate
    import cfg_pkg::*;
#(
    parameter int NUM_OUT = `CFG_NUM_OUT
) (
    input  wire logic               mclk_i,        // reference input clock
    input  wire logic               rstn_i,        // synchronous, active low
    input  wire logic [NUM_OUT-1:0] out_gate_n_i,  // per-output enables, low = on
    input  wire logic [NUM_OUT-1:0] pin_open_i,    // enable pin left floating
    output logic      [NUM_OUT-1:0] fan_out_pos_o, // gated clock, true leg
    output logic      [NUM_OUT-1:0] fan_out_neg_o, // gated clock, complement leg
    output logic      [NUM_OUT-1:0] gate_on_o      // gate state per output
);

    ////////////////////////////////////////////////////////////////////////
    // elaboration checks
    initial begin
        if (NUM_OUT != 2 && NUM_OUT != 4) begin
            $error("cfg_fanout_gate: NUM_OUT must be 2 or 4");
        end
        // latencies must cover the fixed pipeline and end on a rising edge
        if (`CFG_EN_HALF_CYCLES < 5 || (`CFG_EN_HALF_CYCLES % 2) != 1) begin
            $error("cfg_fanout_gate: enable latency must be odd and at least 5");
        end
        if (`CFG_DIS_HALF_CYCLES < 5 || (`CFG_DIS_HALF_CYCLES % 2) != 1) begin
            $error("cfg_fanout_gate: disable latency must be odd and at least 5");
        end
        if (`CFG_DIS_HALF_CYCLES > 35 || `CFG_EN_HALF_CYCLES > 35) begin
            $error("cfg_fanout_gate: latency too long for the 4-bit countdown");
        end
    end

    localparam int PU_W = $clog2(`CFG_POWERUP_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////
    // latency walk for one output, F = falling edge, R = rising edge
    //
    // enable (pin goes low), counted from the usable sample at F1:
    //   F0  first stage takes the new pin level
    //   F1  second stage holds it: this is the sample the gate trusts
    //   F2  state leaves idle and loads the countdown
    //   F3  countdown reaches zero
    //   F4  gate bit set while the clock is low
    //   R   first full high pulse, 3.5 cycles after F1
    //
    // disable (pin goes high), counted from F1 as well:
    //   F2  state leaves running and loads the longer countdown
    //   F5  gate bit cleared while the clock is low
    //   R   the rising edge 4.5 cycles after F1 no longer appears
    //
    // five half cycles are eaten by the second stage, the state entry and
    // the gate step; the countdown covers the rest in whole cycles, so
    // both latencies must be odd numbers of half cycles
    //
    // hazards worth knowing:
    //   - every step needs a falling edge; a stopped input freezes a
    //     pending change, which is why the source must keep toggling
    //   - a running output with a stopped input rests low on the true leg
    //     and high on the complement, and resumes with a full pulse
    //   - a pin that flips back before the countdown ends aborts the
    //     change, so short glitches on the pin never reach the output

    // countdown start value for a latency given in half cycles
    function automatic logic [3:0] lat_load(input int half_cycles);
        int whole;
        whole = (half_cycles - 5) / 2;
        return 4'(whole);
    endfunction : lat_load

    localparam logic [3:0] EN_LOAD  = lat_load(`CFG_EN_HALF_CYCLES);  // enable countdown
    localparam logic [3:0] DIS_LOAD = lat_load(`CFG_DIS_HALF_CYCLES); // disable countdown

    ////////////////////////////////////////////////////////////////////////
    // power-up mask: count input cycles before any output may run
    logic [PU_W-1:0] pu_cnt_reg;   // rising edges seen since reset
    logic            pu_done;      // mask released

    assign pu_done = (pu_cnt_reg == PU_W'(`CFG_POWERUP_CYCLES));

    // count saturates at the mask length
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            pu_cnt_reg <= '0;
        end else if (!pu_done) begin
            pu_cnt_reg <= pu_cnt_reg + PU_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-output logic
    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g++) begin : g_out
            logic       pin_lvl;      // enable level seen at the pad
            logic       sync1_reg;    // first sync stage, falling edge
            logic       sync2_reg;    // second sync stage, falling edge
            logic [3:0] cnt_reg;      // whole-cycle latency countdown
            logic [3:0] cnt_next;
            cfg_gate_t  st_reg;       // gate state
            cfg_gate_t  st_next;
            logic       on_neg_reg;   // gate bit, changed on falling edge

            // floating pin reads low through the weak pull-down
            assign pin_lvl = pin_open_i[g] ? 1'b0 : out_gate_n_i[g];

            // sample on the falling edge, two stages against metastability
            always_ff @(negedge mclk_i) begin
                if (!rstn_i) begin
                    sync1_reg <= 1'b1;
                    sync2_reg <= 1'b1;
                end else begin
                    sync1_reg <= pin_lvl;
                    sync2_reg <= sync1_reg;
                end
            end

            // next state: count whole cycles from the sampled change
            always_comb begin
                st_next  = st_reg;
                cnt_next = cnt_reg;
                unique case (st_reg)
                    CFG_OFF: begin
                        // start only once the power-up mask is released
                        if (!sync2_reg && pu_done) begin
                            st_next  = CFG_WAKE;
                            cnt_next = EN_LOAD;
                        end
                    end
                    CFG_WAKE: begin
                        if (sync2_reg) begin
                            st_next = CFG_OFF;     // aborted before start
                        end else if (cnt_reg == 4'h0) begin
                            st_next = CFG_ON;
                        end else begin
                            cnt_next = cnt_reg - 4'h1;
                        end
                    end
                    CFG_ON: begin
                        // pin high: begin the longer stop countdown
                        if (sync2_reg) begin
                            st_next  = CFG_STOP;
                            cnt_next = DIS_LOAD;
                        end
                    end
                    CFG_STOP: begin
                        if (!sync2_reg) begin
                            st_next = CFG_ON;      // aborted before stop
                        end else if (cnt_reg == 4'h0) begin
                            st_next = CFG_OFF;
                        end else begin
                            cnt_next = cnt_reg - 4'h1;
                        end
                    end
                endcase
            end

            // state and countdown step once per falling edge, i.e. once
            // per whole input cycle; the half cycle comes from the gate
            // being set on a falling edge and used on the next rising one
            always_ff @(negedge mclk_i) begin
                if (!rstn_i) begin
                    st_reg  <= CFG_OFF;
                    cnt_reg <= 4'h0;
                end else begin
                    st_reg  <= st_next;
                    cnt_reg <= cnt_next;
                end
            end

            // gate bit only moves on the falling edge, while clock is low
            always_ff @(negedge mclk_i) begin
                if (!rstn_i) begin
                    on_neg_reg <= 1'b0;
                end else begin
                    on_neg_reg <= (st_next == CFG_ON) || (st_next == CFG_STOP);
                end
            end

            // and-gate keeps whole pulses; stopped clock just holds level
            assign fan_out_pos_o[g] = mclk_i & on_neg_reg;
            assign fan_out_neg_o[g] = ~(mclk_i & on_neg_reg);
            assign gate_on_o[g]     = on_neg_reg;
        end
    endgenerate

endmodule : cfg_fanout_gate

// [tb/cfg_gate_checker.sv]
module cfg_gate_checker #(
    parameter int NUM_OUT = 4
) (
    input wire logic               mclk_i,
    input wire logic               rstn_i,
    input wire logic [NUM_OUT-1:0] out_gate_n_i,
    input wire logic [NUM_OUT-1:0] pin_open_i,
    input wire logic [NUM_OUT-1:0] fan_out_pos_o,
    input wire logic [NUM_OUT-1:0] fan_out_neg_o,
    input wire logic [NUM_OUT-1:0] gate_on_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // falling edge sees the high phase
    default clocking @(negedge mclk_i); endclocking
    default disable iff (!rstn_i);
    AST_NEG_LEG: assert property (fan_out_neg_o == ~fan_out_pos_o) else $error("legs differ");
    AST_HIGH_COPY: assert property (fan_out_pos_o == gate_on_o) else $error("gate not copied");
    AST_LOW_PHASE: assert property (@(posedge mclk_i) fan_out_pos_o == '0) else $error("runt pulse");
    AST_RST_OFF: assert property (disable iff (1'b0) !rstn_i |=> gate_on_o == '0) else $error("on in reset");
    AST_MASK: assert property ($rose(rstn_i) |-> (gate_on_o == '0) [*3]) else $error("mask short");
    AST_EN_LAT: assert property ($fell(out_gate_n_i[0]) && !gate_on_o[0] |-> !gate_on_o[0] [*5] ##1 gate_on_o[0])
        else $error("enable latency wrong");
    AST_DIS_LAT: assert property ($rose(out_gate_n_i[0]) && gate_on_o[0] && !pin_open_i[0]
        |-> gate_on_o[0] [*6] ##1 !gate_on_o[0]) else $error("disable latency wrong");
    AST_OPEN_ON: assert property ($rose(pin_open_i[0]) && !gate_on_o[0] |-> !gate_on_o[0] [*5] ##1 gate_on_o[0])
        else $error("open pin off");
endmodule : cfg_gate_checker

bind cfg_fanout_gate cfg_gate_checker #(.NUM_OUT(NUM_OUT)) u_chk (.mclk_i, .rstn_i, .out_gate_n_i, .pin_open_i,
    .fan_out_pos_o, .fan_out_neg_o, .gate_on_o);

// [tb/cfg_clk_src.sv]
module cfg_clk_src (
    input  wire logic ref_clk_i, // free-running oscillator
    input  wire logic run_i,     // high keeps the clock toggling
    output logic      mclk_o     // clock to the buffer
);
    timeunit 1ns;
    timeprecision 1ps;
    logic run_reg;               // run latched in low phase
    // stop or restart only while low, so no runt edge
    always_ff @(negedge ref_clk_i) run_reg <= run_i;
    assign mclk_o = ref_clk_i & run_reg;
endmodule : cfg_clk_src

// [tb/clock_fanout_sync_output_gate_tb.sv]
module clock_fanout_sync_output_gate_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, run, mclk, rstn;
    logic [3:0] gate_n, open, pos, neg, on;
    int         err_count, checked;
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; $display("Error %0t: %h/%h", $time, a, b); end end
    cfg_clk_src src (.ref_clk_i(clk), .run_i(run), .mclk_o(mclk));
    cfg_fanout_gate #(.NUM_OUT(4)) dut (.mclk_i(mclk), .rstn_i(rstn), .out_gate_n_i(gate_n), .pin_open_i(open),
        .fan_out_pos_o(pos), .fan_out_neg_o(neg), .gate_on_o(on));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // check gate state and both legs in the high phase
    task automatic look(input logic [3:0] e);
        #2;
        `CHK(on, e)
        `CHK(pos, e)
        `CHK(neg, ~e)
    endtask : look
    task automatic finish_test;
        if (err_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    // change enables on a rising edge, stay put early, settle late
    task automatic step(input logic [3:0] g, input logic [3:0] o, input logic [3:0] was, input logic [3:0] e);
        cyc(1);
        gate_n <= g;
        open <= o;
        cyc(2);
        look(was);
        cyc(12);
        look(e);
    endtask : step
    // reset pulse: outputs masked first, then running as the pins say
    task automatic power_up(input logic [3:0] e);
        cyc(1);
        rstn <= 1'b0;
        cyc(4);
        rstn <= 1'b1;
        cyc(3);
        look(4'h0);
        cyc(14);
        look(e);
    endtask : power_up
    // stop the source clock: legs rest, gates hold, then restart
    task automatic stall(input logic [3:0] e);
        cyc(1);
        run <= 1'b0;
        cyc(3);
        #2;
        `CHK(pos, 4'h0)
        `CHK(neg, 4'hF)
        `CHK(on, e)
        cyc(1);
        run <= 1'b1;
        cyc(2);
        look(e);
    endtask : stall
    initial begin
        #20us;
        err_count++;
        finish_test();
    end
    initial begin
        {rstn, run, gate_n, open, err_count, checked} = '0;
        run = 1'b1;
        power_up(4'hF);
        step(4'h5, 4'h0, 4'hF, 4'hA);
        step(4'h0, 4'h0, 4'hA, 4'hF);
        step(4'hF, 4'h0, 4'hF, 4'h0);
        step(4'hF, 4'h3, 4'h0, 4'h3);
        power_up(4'h3);
        stall(4'h3);
        finish_test();
    end
endmodule : clock_fanout_sync_output_gate_tb
